// ===== src/sync_byte_transmitter.sv
// byte-synchronous transmitter with sync fill, parity, crc and AHB-Lite registers
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module sync_byte_transmitter (
   input  wire logic        clk_sys,              // 25 MHz system clock
   input  wire logic        reset,                // synchronous, active high
   input  wire logic        hsel,                 // AHB-Lite slave select
   input  wire logic [31:0] haddr,                // byte address
   input  wire logic [1:0]  htrans,               // transfer type
   input  wire logic        hwrite,               // write when high
   input  wire logic [2:0]  hsize,                // word transfers only
   input  wire logic [31:0] hwdata,               // write data
   input  wire logic        hready,               // bus ready
   output logic      [31:0] hrdata,               // read data
   output logic             hreadyout,            // always ready
   output logic             hresp,                // always okay
   input  wire logic        transmit_bit_clock,   // x1 link clock from the line
   input  wire logic        clear_to_send_n,      // modem clear-to-send, low active
   output logic             tx_data,              // serial data out
   output logic             transmit_dma_request, // dma service request
   output logic             tx_irq,               // transmit interrupt pending
   output logic             ext_irq               // external/status interrupt pending
);
   import sync_tx_pkg::*;

   state_t st;
   state_t next_st;

   // reset image: line marking, latch set, buffer empty
   function automatic state_t reset_value();
      state_t r;
      r           = '0;
      r.ctrl      = CTRL_RST;
      r.sync_word = SYNC_RST;
      r.crc       = CRC_RST;
      r.kind      = ST_MARK;
      r.line      = 1'b1;
      r.eom_latch = 1'b1;
      r.tx_empty  = 1'b1;
      r.ready     = 1'b1;
      return r;
   endfunction : reset_value

   // serial crc step, x16 fed back into the chosen taps
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                            input logic ccitt);
      logic [15:0] poly;
      poly = ccitt ? POLY_CCITT : POLY_CRC16;
      if (b ^ c[15]) begin
         return {c[14:0], 1'b0} ^ poly;
      end
      return {c[14:0], 1'b0};
   endfunction : crc_step

   logic        fall;
   logic        en;
   logic        wr_ok;
   logic        rd_ok;
   logic [31:0] rd_val;
   logic [3:0]  nb;
   logic [7:0]  d;
   logic        par;
   logic [15:0] syncpat;
   logic [15:0] rev;
   logic        bit_out;
   state_t      rst_img;

   always_comb begin
      next_st = st;
      nb      = 4'h0;
      d       = 8'h00;
      par     = 1'b0;
      rev     = 16'h0000;
      bit_out = 1'b1;
      rst_img = reset_value();

      // two-stage synchronisers; edges are found between stage two and a third copy
      next_st.clk_s1   = transmit_bit_clock;
      next_st.clk_s2   = st.clk_s1;
      next_st.clk_prev = st.clk_s2;
      next_st.cts_s1   = clear_to_send_n;
      next_st.cts_s2   = st.cts_s1;
      fall = st.clk_prev & ~st.clk_s2;
      en   = st.ctrl.tx_en & (~st.ctrl.auto_en | ~st.cts_s2);

      // sync pattern: first word then second, or first word repeated
      syncpat = st.ctrl.bisync ? st.sync_word
                               : {st.sync_word[7:0], st.sync_word[7:0]};

      // address phase of AHB-Lite; zero wait states so hready is our own
      rd_ok = hsel & hready & htrans[1] & ~hwrite;
      next_st.dph_valid = hsel & hready & htrans[1];
      next_st.dph_write = hwrite;
      next_st.dph_addr  = haddr[7:0];
      next_st.ready     = 1'b1;
      case (haddr[7:0])
         OFF_CTRL:   rd_val = {21'h000000, st.ctrl};
         OFF_SYNC:   rd_val = {16'h0000, st.sync_word};
         OFF_DATA:   rd_val = {24'h000000, st.buf_data};
         OFF_STATUS: rd_val = {25'h0000000, st.line, ~st.cts_s2, st.ext_int,
                               st.tx_int, st.underrun, st.eom_latch, st.tx_empty};
         default:    rd_val = 32'h00000000;
      endcase
      if (rd_ok) begin
         next_st.rdata = rd_val;
      end

      // data phase of a write: control words and the tx, eom and ext clears land first,
      // so any hardware set computed below in the same cycle wins
      wr_ok = st.dph_valid & st.dph_write;
      if (wr_ok && st.dph_addr == OFF_CTRL) begin
         next_st.ctrl = ctrl_t'(hwdata[10:0]);
      end
      if (wr_ok && st.dph_addr == OFF_SYNC) begin
         next_st.sync_word = hwdata[15:0];
      end
      if (wr_ok && st.dph_addr == OFF_CMD) begin
         if (hwdata[CMD_RST_TXINT]) begin
            next_st.tx_int = 1'b0;
         end
         if (hwdata[CMD_RST_EOM]) begin
            next_st.eom_latch = 1'b0;
         end
         if (hwdata[CMD_RST_EXT]) begin
            next_st.ext_int = 1'b0;
         end
      end
      if (wr_ok && st.dph_addr == OFF_DATA) begin
         next_st.tx_int = 1'b0;
      end

      // character boundary: pick what the shifter takes next
      if (fall && st.cnt == 5'h00) begin
         next_st.pos = 5'h00;
         if (!en) begin
            next_st.kind = ST_MARK;
         end else if (st.buf_full) begin
            // length and crc enable are taken now, not at write time
            nb = (st.ctrl.bpc == 3'h0) ? BITS_FULL[3:0] : {1'b0, st.ctrl.bpc};
            for (int i = 0; i < 8; i++) begin
               d[i] = st.buf_data[i] & (i < nb);
            end
            par = (^d) ^ st.ctrl.parity_odd;
            next_st.shreg = {8'h00, d};
            if (st.ctrl.parity_en) begin
               next_st.shreg[nb] = par;
            end
            next_st.nbits    = {1'b0, nb};
            next_st.cnt      = 5'({1'b0, nb} + {4'h0, st.ctrl.parity_en});
            next_st.kind     = ST_DATA;
            next_st.crc_inc  = st.ctrl.crc_en;
            next_st.buf_full = 1'b0;
            next_st.tx_empty = 1'b1;
            next_st.tx_int   = 1'b1;
            next_st.underrun = 1'b0;
         end else if (!st.eom_latch) begin
            // underrun with the latch cleared: ship the crc, most significant first
            for (int i = 0; i < 16; i++) begin
               rev[i] = st.crc[15 - i];
            end
            next_st.shreg     = rev;
            next_st.cnt       = BITS_CRC;
            next_st.nbits     = 5'h00;
            next_st.kind      = ST_CRC;
            next_st.crc_inc   = 1'b0;
            next_st.eom_latch = 1'b1;
            next_st.ext_int   = 1'b1;
            next_st.underrun  = 1'b1;
            next_st.tx_empty  = 1'b0;
         end else begin
            // fill sync never feeds the crc and never carries parity
            next_st.shreg    = st.ctrl.bisync ? st.sync_word
                                              : {8'h00, st.sync_word[7:0]};
            next_st.cnt      = st.ctrl.bisync ? BITS_BI_SYNC : BITS_MONO_SYNC;
            next_st.nbits    = 5'h00;
            next_st.kind     = ST_SYNC;
            next_st.crc_inc  = 1'b0;
            next_st.underrun = 1'b1;
            if (st.kind == ST_DATA) begin
               next_st.tx_int   = 1'b1;
               next_st.tx_empty = 1'b1;
               next_st.ext_int  = 1'b1;
            end
            if (st.kind == ST_CRC) begin
               next_st.tx_int   = 1'b1;
               next_st.tx_empty = 1'b1;
            end
         end
      end

      // shift one bit per falling edge, least significant first
      if (fall && next_st.kind != ST_MARK && next_st.cnt != 5'h00) begin
         if (next_st.kind == ST_CRC && !en) begin
            bit_out = syncpat[next_st.pos[3:0]];
         end else begin
            bit_out = next_st.shreg[0];
         end
         next_st.line = bit_out;
         if (next_st.kind == ST_DATA && next_st.crc_inc && next_st.pos < next_st.nbits) begin
            next_st.crc = crc_step(st.crc, bit_out, st.ctrl.ccitt);
         end
         next_st.shreg = {1'b0, next_st.shreg[15:1]};
         next_st.cnt   = 5'(next_st.cnt - 5'h01);
         next_st.pos   = 5'(next_st.pos + 5'h01);
      end else if (fall && next_st.kind == ST_MARK) begin
         next_st.line = 1'b1;
      end

      // a crc reset wins over the bit being accumulated this cycle
      if (wr_ok && st.dph_addr == OFF_CMD && hwdata[CMD_RST_CRC]) begin
         next_st.crc = CRC_RST;
      end

      // buffer write last: a load and a write in one cycle leave the new byte held
      if (wr_ok && st.dph_addr == OFF_DATA) begin
         next_st.buf_data = hwdata[7:0];
         next_st.buf_full = 1'b1;
         next_st.tx_empty = 1'b0;
      end

      // break acts at once and throws away both characters
      if (next_st.ctrl.send_break) begin
         next_st.line     = 1'b0;
         next_st.buf_full = 1'b0;
         next_st.kind     = ST_MARK;
         next_st.cnt      = 5'h00;
         next_st.tx_empty = 1'b1;
      end else if (next_st.kind == ST_MARK) begin
         next_st.line = 1'b1;
      end

      // dma wants a byte whenever the enabled transmitter has an empty buffer and no break is set
      next_st.dma = en & ~next_st.buf_full & ~next_st.ctrl.send_break;

      // software reset: everything but the synchronisers and bus phase
      if (wr_ok && st.dph_addr == OFF_CMD && hwdata[CMD_SOFT_RESET]) begin
         rst_img.clk_s1    = next_st.clk_s1;
         rst_img.clk_s2    = next_st.clk_s2;
         rst_img.clk_prev  = next_st.clk_prev;
         rst_img.cts_s1    = next_st.cts_s1;
         rst_img.cts_s2    = next_st.cts_s2;
         rst_img.dph_valid = next_st.dph_valid;
         rst_img.dph_write = next_st.dph_write;
         rst_img.dph_addr  = next_st.dph_addr;
         rst_img.rdata     = next_st.rdata;
         next_st           = rst_img;
      end
   end

   // single state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st <= reset_value();
      end else begin
         st <= next_st;
      end
   end

   // every output but hresp straight from the state flops; hresp is tied low
   assign hrdata               = st.rdata;
   assign hreadyout            = st.ready;
   assign hresp                = 1'b0;
   assign tx_data              = st.line;
   assign transmit_dma_request = st.dma;
   assign tx_irq               = st.tx_int;
   assign ext_irq              = st.ext_int;

endmodule : sync_byte_transmitter

// ===== src/sync_tx_pkg.sv
// constants, register map and carrier types of the byte-synchronous transmitter
package sync_tx_pkg;

   // register byte offsets on the AHB-Lite slave (word aligned)
   localparam logic [7:0]  OFF_CTRL        = 8'h00;
   localparam logic [7:0]  OFF_SYNC        = 8'h04;
   localparam logic [7:0]  OFF_DATA        = 8'h08;
   localparam logic [7:0]  OFF_CMD         = 8'h0C;
   localparam logic [7:0]  OFF_STATUS      = 8'h10;

   // command register bit positions (write one to act)
   localparam int          CMD_RST_CRC     = 0;
   localparam int          CMD_RST_TXINT   = 1;
   localparam int          CMD_RST_EOM     = 2;
   localparam int          CMD_RST_EXT     = 3;
   localparam int          CMD_SOFT_RESET  = 4;

   // reset values
   localparam logic [10:0] CTRL_RST        = 11'h000;
   localparam logic [15:0] SYNC_RST        = 16'h0000;
   localparam logic [15:0] CRC_RST         = 16'h0000;

   // crc polynomials, x^16 term implied
   localparam logic [15:0] POLY_CRC16      = 16'h8005;
   localparam logic [15:0] POLY_CCITT      = 16'h1021;

   // character lengths in bits
   localparam logic [4:0]  BITS_FULL       = 5'h08;
   localparam logic [4:0]  BITS_MONO_SYNC  = 5'h08;
   localparam logic [4:0]  BITS_BI_SYNC    = 5'h10;
   localparam logic [4:0]  BITS_CRC        = 5'h10;

   // what the shift register currently holds (one-hot)
   typedef enum logic [3:0] {
      ST_MARK = 4'b0001,
      ST_DATA = 4'b0010,
      ST_SYNC = 4'b0100,
      ST_CRC  = 4'b1000
   } kind_t;

   // control register, bit 0 at the bottom
   typedef struct packed {
      logic [2:0] bpc;         // bits per character, 0 means eight
      logic       send_break;  // force spacing
      logic       bisync;      // two sync words instead of one
      logic       ccitt;       // select x16+x12+x5+1
      logic       crc_en;      // include next loaded character in crc
      logic       parity_odd;  // odd parity when set
      logic       parity_en;   // append parity to buffered characters
      logic       auto_en;     // clear-to-send gates the enable
      logic       tx_en;       // transmitter enable
   } ctrl_t;

   // complete state of the transmitter
   typedef struct packed {
      ctrl_t       ctrl;
      logic [15:0] sync_word;  // second word high, first word low
      logic [7:0]  buf_data;
      logic        buf_full;
      logic        tx_empty;
      logic        eom_latch;
      logic        underrun;
      logic        tx_int;
      logic        ext_int;
      logic [15:0] crc;
      kind_t       kind;
      logic [4:0]  cnt;        // bits still to send
      logic [4:0]  pos;        // bits already sent
      logic [4:0]  nbits;      // data bits that feed the crc
      logic [15:0] shreg;
      logic        crc_inc;
      logic        clk_s1;
      logic        clk_s2;
      logic        clk_prev;
      logic        cts_s1;
      logic        cts_s2;
      logic        line;
      logic        dma;
      logic        dph_valid;
      logic        dph_write;
      logic [7:0]  dph_addr;
      logic [31:0] rdata;
      logic        ready;
   } state_t;

endpackage : sync_tx_pkg

// ===== verification/sync_tx_assertions.sv
// port-level checker of the byte-synchronous transmitter
`timescale 1ns/1ps
module sync_tx_checker (
   input wire logic        clk_sys,              // clock
   input wire logic        reset,                // sync reset
   input wire logic        hsel,                 // select
   input wire logic [31:0] haddr,                // address
   input wire logic [1:0]  htrans,               // transfer type
   input wire logic        hwrite,               // write
   input wire logic [31:0] hwdata,               // write data
   input wire logic        hready,               // bus ready
   input wire logic        transmit_bit_clock,   // link clock
   input wire logic        tx_data,              // serial out
   input wire logic        transmit_dma_request, // dma request
   input wire logic        tx_irq,               // tx interrupt
   input wire logic        ext_irq               // status interrupt
);
   import sync_tx_pkg::*;
   logic       lk_q;     // link clock one edge ago
   logic       wr_dph;   // write data phase now
   logic [7:0] wr_adr;   // its address
   logic [3:0] fall_age; // edges since the link clock fell
   logic [3:0] wr_age;   // edges since a write data phase
   // ages saturate so that an old event never looks recent
   always_ff @(posedge clk_sys) begin
      lk_q   <= transmit_bit_clock;
      wr_dph <= hsel && hready && htrans[1] && hwrite;
      wr_adr <= haddr[7:0];
      if (reset) begin
         fall_age <= 4'hF;
         wr_age   <= 4'hF;
      end else begin
         fall_age <= (lk_q && !transmit_bit_clock) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
         wr_age   <= wr_dph ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_rst_mark;
      disable iff (1'b0) reset |=> tx_data && !transmit_dma_request && !tx_irq && !ext_irq;
   endproperty
   a_rst_mark: assert property (p_rst_mark)
      else $error("line or flags wrong after reset");
   property p_bit_edge;
      $changed(tx_data) |-> fall_age <= 4'h6 || wr_age <= 4'h3;
   endproperty
   a_bit_edge: assert property (p_bit_edge)
      else $error("line changed away from a link falling edge");
   property p_dma_cause;
      $rose(transmit_dma_request) |-> fall_age <= 4'h6 || wr_age <= 4'h3;
   endproperty
   a_dma_cause: assert property (p_dma_cause)
      else $error("dma request rose without cause");
   property p_irq_cause;
      $rose(tx_irq) |-> fall_age <= 4'h6 || wr_age <= 4'h3;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("tx interrupt rose without a shifter load");
   property p_irq_clear;
      $fell(tx_irq) |-> wr_age <= 4'h2;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("tx interrupt dropped without a write");
   property p_ext_cause;
      $rose(ext_irq) |-> fall_age <= 4'h6;
   endproperty
   a_ext_cause: assert property (p_ext_cause)
      else $error("status interrupt rose off a character boundary");
   property p_ext_clear;
      $fell(ext_irq) |-> wr_age <= 4'h2;
   endproperty
   a_ext_clear: assert property (p_ext_clear)
      else $error("status interrupt dropped without a write");
   property p_brk;
      wr_dph && wr_adr == OFF_CTRL && hwdata[7] |-> ##[1:3] !tx_data [*8];
   endproperty
   a_brk: assert property (p_brk)
      else $error("break did not space the line");
endmodule : sync_tx_checker

bind sync_byte_transmitter sync_tx_checker i_chk (.clk_sys(clk_sys), .reset(reset),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .transmit_bit_clock(transmit_bit_clock), .tx_data(tx_data),
   .transmit_dma_request(transmit_dma_request), .tx_irq(tx_irq), .ext_irq(ext_irq));

// ===== verification/line_receiver_model.sv
// remote receiver: clocks the line in bursts and collects the bits
`timescale 1ns/1ps
module line_receiver_model (
   input  wire logic        go,       // start a burst
   input  wire logic [7:0]  want,     // link periods per burst
   input  wire logic        tx_data,  // serial line
   output logic             link_clk, // x1 clock, idle high
   output logic             done,     // burst finished
   output logic      [63:0] bits      // newest bit at the top
);
   initial begin
      link_clk = 1'b1;
      done     = 1'b1;
      bits     = 64'h0;
   end
   // sample just before the next fall: the bit lags its fall by a few system clocks
   always @(posedge go) begin
      done = 1'b0;
      #37;
      for (int i = 0; i < int'(want); i++) begin
         link_clk = 1'b0;
         #160;
         link_clk = 1'b1;
         #150;
         bits = {tx_data, bits[63:1]};
         #10;
      end
      done = 1'b1;
   end
endmodule : line_receiver_model

// ===== verification/testbench.sv
// self-checking bench of the byte-synchronous transmitter
`timescale 1ns/1ps
module testbench;
   import sync_tx_pkg::*;
   localparam logic [7:0] DB = 8'h31;
   logic        clk_sys = 1'b0;
   logic        reset   = 1'b1;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic        cts_n   = 1'b0;
   logic        go      = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [7:0]  want    = 8'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic        hready, hresp, tx_data, dma, tx_irq, ext_irq, link_clk, done;
   logic [31:0] hrdata, rv, s;
   logic [63:0] bits;
   logic [15:0] c;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;

   always #20 clk_sys = ~clk_sys;

   sync_byte_transmitter i_dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .transmit_bit_clock(link_clk),
      .clear_to_send_n(cts_n), .tx_data(tx_data), .transmit_dma_request(dma),
      .tx_irq(tx_irq), .ext_irq(ext_irq));
   line_receiver_model i_rx (.go(go), .want(want), .tx_data(tx_data), .link_clk(link_clk),
      .done(done), .bits(bits));

   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // the whole run needs little more than a thousand cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask : chk

   // address phase held until ready, then data phase held until ready again
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rv = hrdata;
   endtask : xfer

   task link(input logic [7:0] n);
      @(posedge clk_sys);
      want <= n;
      go   <= 1'b1;
      repeat (2) @(posedge clk_sys);
      while (done !== 1'b1) @(posedge clk_sys);
      go <= 1'b0;
   endtask : link

   task rst;
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
   endtask : rst

   initial begin
      rst();
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk("eom latch", 32'h1, {31'h0, rv[1]});
      chk("idle line", 32'h1, {31'h0, tx_data});
      chk("okay response", 32'h0, {31'h0, hresp});
      xfer(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rv);
      $display("test reset done");
      // single then double sync fill
      for (int m = 0; m < 2; m++) begin
         rst();
         xfer(1'b1, OFF_SYNC, 32'hC35A);
         xfer(1'b1, OFF_CTRL, m ? 32'h41 : 32'h1);
         link(8'h10);
         chk("sync fill", m ? 32'hC35A : 32'h5A5A, {16'h0, bits[63:48]});
      end
      $display("test sync fill done");
      // seven-bit character, odd parity, loaded before enable
      rst();
      xfer(1'b1, OFF_SYNC, 32'h5A);
      xfer(1'b1, OFF_CTRL, 32'h70C);
      xfer(1'b1, OFF_DATA, 32'hA6);
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk("empty after write", 32'h0, {31'h0, rv[0]});
      xfer(1'b1, OFF_CTRL, 32'h70D);
      link(8'h10);
      chk("data then sync", 32'h5A26, {16'h0, bits[63:48]});
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk("sync end status", 32'h7, {29'h0, rv[2:0]});
      chk("pins", 32'h7, {29'h0, tx_irq, ext_irq, dma});
      xfer(1'b1, OFF_CMD, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk("irq cleared", 32'h0, {31'h0, tx_irq});
      $display("test sync end done");
      // crc termination under each polynomial
      for (int p = 0; p < 2; p++) begin
         rst();
         xfer(1'b1, OFF_SYNC, 32'h5A);
         xfer(1'b1, OFF_CMD, 32'h1);
         xfer(1'b1, OFF_CMD, 32'h4);
         xfer(1'b1, OFF_DATA, {24'h0, DB});
         xfer(1'b1, OFF_CTRL, p ? 32'h31 : 32'h11);
         link(8'h10);
         xfer(1'b0, OFF_STATUS, 32'h0);
         chk("during crc", 32'h2, {30'h0, rv[1:0]});
         link(8'h10);
         c = 16'h0;
         for (int i = 0; i < 8; i++)
            c = {c[14:0], 1'b0} ^ ({16{c[15] ^ DB[i]}} & (p ? POLY_CCITT : POLY_CRC16));
         s = {8'h5A, 16'h0, DB};
         for (int j = 0; j < 16; j++) s[8 + j] = c[15 - j];
         chk("crc frame", s, bits[63:32]);
         xfer(1'b0, OFF_STATUS, 32'h0);
         chk("crc end status", 32'h3, {30'h0, rv[1:0]});
         chk("crc end irqs", 32'h3, {30'h0, tx_irq, ext_irq});
         xfer(1'b1, OFF_CMD, 32'h8);
         repeat (2) @(posedge clk_sys);
         chk("ext irq cleared", 32'h0, {31'h0, ext_irq});
      end
      $display("test crc end done");
      // break while disabled, with a byte waiting
      rst();
      xfer(1'b1, OFF_DATA, 32'h55);
      xfer(1'b1, OFF_CTRL, 32'h80);
      repeat (12) @(posedge clk_sys);
      chk("break line", 32'h0, {31'h0, tx_data});
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk("break drops byte", 32'h1, {31'h0, rv[0]});
      xfer(1'b1, OFF_CTRL, 32'h0);
      repeat (4) @(posedge clk_sys);
      chk("mark after break", 32'h1, {31'h0, tx_data});
      // software reset brings back the latch and an empty buffer
      xfer(1'b1, OFF_CMD, 32'h4);
      xfer(1'b1, OFF_DATA, 32'h12);
      xfer(1'b1, OFF_CMD, 32'h10);
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk("soft reset status", 32'h3, {30'h0, rv[1:0]});
      chk("soft reset line", 32'h1, {31'h0, tx_data});
      $display("test break done");
      // auto enable with clear-to-send withdrawn keeps the line marking
      rst();
      cts_n <= 1'b1;
      xfer(1'b1, OFF_CTRL, 32'h3);
      link(8'h8);
      chk("auto enable", 32'hFF, {24'h0, bits[63:56]});
      $display("test auto enable done");
      end_sim();
   end
endmodule : testbench
